// ---- hw/csf_pkg.sv ----
// Constants for the CPU status flag upper-bits register bank
// Operation
// - Bit 11 reads the OR of both accumulator overflow flags.
// - Bit 10 reads the OR of both sticky saturation flags.
// - Bit 9 is high while a hardware do-loop runs.
// - Bit 8 takes the carry into bit 4 (byte) or bit 8 (word).
// - Priority bits ignore writes while nesting disable is set.
// - A status write with bit 10 set loads both sticky saturation flags directly.
// - Writing zero to the sticky summary clears both sticky flags.
// - Priority level is core control bit 3 above the three status bits.
// - Each sticky saturation flag holds until explicitly cleared.
package csf_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_CORE_CTL = 5'h04;
  localparam logic [4:0] OFS_IRQ_CTL = 5'h08;
  localparam logic [4:0] OFS_EVT_STAT = 5'h0c;
  localparam logic [4:0] OFS_EVT_CLR = 5'h10;
  localparam logic [4:0] OFS_EVT_EN = 5'h14;
  // ---------------------------------------------------------------
  // Status word and control register field positions
  // ---------------------------------------------------------------
  localparam int BIT_OVF_A = 15;
  localparam int BIT_OVF_B = 14;
  localparam int BIT_SAT_A = 13;
  localparam int BIT_SAT_B = 12;
  localparam int BIT_OVF_ANY = 11;
  localparam int BIT_SAT_ANY = 10;
  localparam int BIT_LOOP = 9;
  localparam int BIT_HALF = 8;
  localparam int BIT_PRIO_LO = 5;
  localparam int BIT_PRIO_MSB = 3;
  localparam int BIT_NEST_DIS = 15;
  // ---------------------------------------------------------------
  // Event bits and reset values
  // ---------------------------------------------------------------
  localparam int EVT_SAT = 0;
  localparam int EVT_OVF = 1;
  localparam int EVT_LOOP_END = 2;
  localparam int EVT_W = 3;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0] RST_PRIO = 3'h0;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;
endpackage

// ---- hw/csf_status_bank.sv ----
// CPU status flag bank with its Avalon-MM register slave
`timescale 1ns/10ps
module csf_status_bank
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic acc_alpha_overflow,
  input wire logic acc_beta_overflow,
  input wire logic acc_alpha_clip_event,
  input wire logic acc_beta_clip_event,
  input wire logic loop_active_in,
  input wire logic alu_valid,
  input wire logic alu_byte_op,
  input wire logic alu_subtract,
  input wire logic [15:0] alu_opa,
  input wire logic [15:0] alu_opb,
  output logic [3:0] cpu_priority_level,
  output logic irq
);
  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Merge a 16-bit register with the two low write lanes
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0])
    begin
      res[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // Carry into bit 4 (byte) or bit 8 (word); subtraction adds the complement
  function automatic logic half_carry(input logic [15:0] a, input logic [15:0] b,
                                      input logic sub, input logic byte_op);
    logic [15:0] bb;
    logic [8:0] sum8;
    logic [4:0] sum4;
    bb = sub ? ~b : b;
    sum8 = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, sub};
    sum4 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    return byte_op ? sum4[4] : sum8[8];
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  logic ovf_a;
  logic ovf_b;
  logic next_ovf_a;
  logic next_ovf_b;
  logic sat_a;
  logic sat_b;
  logic next_sat_a;
  logic next_sat_b;
  logic loop_flag;
  logic next_loop_flag;
  logic half_flag;
  logic next_half_flag;
  logic [2:0] prio;
  logic [2:0] next_prio;
  logic [15:0] core_ctl;
  logic [15:0] next_core_ctl;
  logic [15:0] irq_ctl;
  logic [15:0] next_irq_ctl;
  logic [csf_pkg::EVT_W-1:0] evt_stat;
  logic [csf_pkg::EVT_W-1:0] next_evt_stat;
  logic [csf_pkg::EVT_W-1:0] evt_en;
  logic [csf_pkg::EVT_W-1:0] next_evt_en;
  logic [15:0] status_word;
  logic wr_go;
  logic rd_go;
  logic hc_calc;
  logic [15:0] st_merged;
  logic [csf_pkg::EVT_W-1:0] evt_hit;

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // One wait cycle so read data can come from a flop
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_go = avs_write & ack;
  assign rd_go = avs_read & ~ack;

  // Ack toggles for exactly one cycle per request
  always_comb
  begin
    next_ack = (avs_read | avs_write) & ~ack;
  end

  // ---------------------------------------------------------------
  // Status word view
  // ---------------------------------------------------------------
  // Summaries come straight from the flag flops, never lagging them
  always_comb
  begin
    status_word = csf_pkg::RST_WORD;
    status_word[csf_pkg::BIT_OVF_A] = ovf_a;
    status_word[csf_pkg::BIT_OVF_B] = ovf_b;
    status_word[csf_pkg::BIT_SAT_A] = sat_a;
    status_word[csf_pkg::BIT_SAT_B] = sat_b;
    status_word[csf_pkg::BIT_OVF_ANY] = ovf_a | ovf_b;
    status_word[csf_pkg::BIT_SAT_ANY] = sat_a | sat_b;
    status_word[csf_pkg::BIT_LOOP] = loop_flag;
    status_word[csf_pkg::BIT_HALF] = half_flag;
    status_word[csf_pkg::BIT_PRIO_LO +: 3] = prio;
  end

  // Priority level seen by the interrupt controller
  assign cpu_priority_level = {core_ctl[csf_pkg::BIT_PRIO_MSB], prio};

  assign hc_calc = half_carry(alu_opa, alu_opb, alu_subtract, alu_byte_op);
  assign st_merged = lane_merge(status_word, avs_writedata, avs_byteenable);

  // ---------------------------------------------------------------
  // Flag next-state logic
  // ---------------------------------------------------------------
  // Hardware saturation beats a software clear in the same cycle
  always_comb
  begin
    next_ovf_a = acc_alpha_overflow;
    next_ovf_b = acc_beta_overflow;
    next_loop_flag = loop_active_in;
    next_half_flag = half_flag;
    next_sat_a = sat_a;
    next_sat_b = sat_b;
    next_prio = prio;
    next_core_ctl = core_ctl;
    next_irq_ctl = irq_ctl;
    if (wr_go && avs_address == csf_pkg::OFS_STATUS)
    begin
      next_half_flag = st_merged[csf_pkg::BIT_HALF];
      if (!st_merged[csf_pkg::BIT_SAT_ANY])
      begin
        next_sat_a = 1'b0;
        next_sat_b = 1'b0;
      end
      else
      begin
        next_sat_a = st_merged[csf_pkg::BIT_SAT_A];
        next_sat_b = st_merged[csf_pkg::BIT_SAT_B];
      end
      if (!irq_ctl[csf_pkg::BIT_NEST_DIS])
      begin
        next_prio = st_merged[csf_pkg::BIT_PRIO_LO +: 3];
      end
    end
    if (wr_go && avs_address == csf_pkg::OFS_CORE_CTL)
    begin
      next_core_ctl = lane_merge(core_ctl, avs_writedata, avs_byteenable);
    end
    if (wr_go && avs_address == csf_pkg::OFS_IRQ_CTL)
    begin
      next_irq_ctl = lane_merge(irq_ctl, avs_writedata, avs_byteenable);
    end
    if (alu_valid)
    begin
      next_half_flag = hc_calc;
    end
    if (acc_alpha_clip_event)
    begin
      next_sat_a = 1'b1;
    end
    if (acc_beta_clip_event)
    begin
      next_sat_b = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Event status, enable and read mux
  // ---------------------------------------------------------------
  // New events win over a clear landing in the same cycle
  always_comb
  begin
    evt_hit = '0;
    evt_hit[csf_pkg::EVT_SAT] = acc_alpha_clip_event | acc_beta_clip_event;
    evt_hit[csf_pkg::EVT_OVF] = (acc_alpha_overflow & ~ovf_a) | (acc_beta_overflow & ~ovf_b);
    evt_hit[csf_pkg::EVT_LOOP_END] = loop_flag & ~loop_active_in;
    next_evt_stat = evt_stat;
    next_evt_en = evt_en;
    if (wr_go && avs_address == csf_pkg::OFS_EVT_CLR)
    begin
      next_evt_stat = evt_stat & ~avs_writedata[csf_pkg::EVT_W-1:0];
    end
    if (wr_go && avs_address == csf_pkg::OFS_EVT_EN)
    begin
      next_evt_en = avs_writedata[csf_pkg::EVT_W-1:0];
    end
    next_evt_stat = next_evt_stat | evt_hit;
    next_readdata = avs_readdata;
    if (rd_go)
    begin
      unique case (avs_address)
        csf_pkg::OFS_STATUS: next_readdata = {16'h0000, status_word};
        csf_pkg::OFS_CORE_CTL: next_readdata = {16'h0000, core_ctl};
        csf_pkg::OFS_IRQ_CTL: next_readdata = {16'h0000, irq_ctl};
        csf_pkg::OFS_EVT_STAT: next_readdata = {29'h0000000, evt_stat};
        csf_pkg::OFS_EVT_EN: next_readdata = {29'h0000000, evt_en};
        default: next_readdata = 32'h00000000; // Unmapped and write-only read zero
      endcase
    end
  end

  assign irq = |(evt_stat & evt_en);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // All state takes constants under reset
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
      ovf_a <= 1'b0;
      ovf_b <= 1'b0;
      sat_a <= 1'b0;
      sat_b <= 1'b0;
      loop_flag <= 1'b0;
      half_flag <= 1'b0;
      prio <= csf_pkg::RST_PRIO;
      core_ctl <= csf_pkg::RST_WORD;
      irq_ctl <= csf_pkg::RST_WORD;
      evt_stat <= csf_pkg::RST_EVT;
      evt_en <= csf_pkg::RST_EVT;
    end
    else
    begin
      ack <= next_ack;
      avs_readdata <= next_readdata;
      ovf_a <= next_ovf_a;
      ovf_b <= next_ovf_b;
      sat_a <= next_sat_a;
      sat_b <= next_sat_b;
      loop_flag <= next_loop_flag;
      half_flag <= next_half_flag;
      prio <= next_prio;
      core_ctl <= next_core_ctl;
      irq_ctl <= next_irq_ctl;
      evt_stat <= next_evt_stat;
      evt_en <= next_evt_en;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic st_wr;
  assign st_wr = wr_go && avs_address == csf_pkg::OFS_STATUS && avs_byteenable[1];

  ovf_summary_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    status_word[csf_pkg::BIT_OVF_ANY] == ($past(acc_alpha_overflow) | $past(acc_beta_overflow)))
    else $error("overflow summary wrong");
  sat_summary_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    acc_alpha_clip_event |=> status_word[csf_pkg::BIT_SAT_ANY])
    else $error("sticky summary missed event");
  loop_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    loop_active_in |=> status_word[csf_pkg::BIT_LOOP])
    else $error("loop flag not set");
  half_carry_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    alu_valid |=> half_flag == $past(hc_calc))
    else $error("half carry wrong");
  prio_lock_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    irq_ctl[csf_pkg::BIT_NEST_DIS] |=> $stable(prio))
    else $error("priority changed while locked");
  sat_load_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_wr && avs_writedata[csf_pkg::BIT_SAT_ANY] && !acc_alpha_clip_event
    |=> sat_a == $past(avs_writedata[csf_pkg::BIT_SAT_A]))
    else $error("sticky load failed");
  sat_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_wr && !avs_writedata[csf_pkg::BIT_SAT_ANY] && !acc_alpha_clip_event
    && !acc_beta_clip_event |=> !sat_a && !sat_b)
    else $error("sticky clear failed");
  prio_level_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cpu_priority_level[3] == core_ctl[csf_pkg::BIT_PRIO_MSB]
    && cpu_priority_level[2:0] == status_word[7:5])
    else $error("priority level mismatch");
  sat_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    sat_b && !wr_go ##1 !wr_go |-> sat_b)
    else $error("sticky flag dropped");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    evt_hit[csf_pkg::EVT_SAT] && evt_en[csf_pkg::EVT_SAT]
    && !(wr_go && avs_address == csf_pkg::OFS_EVT_EN) |=> irq)
    else $error("interrupt not raised");
endmodule

// ---- tb/csf_core_model.sv ----
// Behavioural model of the CPU core feeding the status flag bank
`timescale 1ns/10ps
module csf_core_model
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [1:0] req_ovf,
  input wire logic [1:0] req_clip,
  input wire logic req_loop,
  input wire logic req_valid,
  input wire logic req_byte,
  input wire logic req_sub,
  input wire logic [15:0] req_opa,
  input wire logic [15:0] req_opb,
  output logic [1:0] ovf,
  output logic [1:0] clip,
  output logic loop_active,
  output logic alu_valid,
  output logic alu_byte_op,
  output logic alu_subtract,
  output logic [15:0] alu_opa,
  output logic [15:0] alu_opb
);
  // Core outputs change one edge after the bench asks
  // Idle operands toggle every cycle so stale values never look valid
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ovf <= 2'h0;
      clip <= 2'h0;
      loop_active <= 1'b0;
      alu_valid <= 1'b0;
      alu_byte_op <= 1'b0;
      alu_subtract <= 1'b0;
      alu_opa <= 16'h0000;
      alu_opb <= 16'h0000;
    end
    else
    begin
      ovf <= req_ovf;
      clip <= req_clip; // Single-cycle clip pulses
      loop_active <= req_loop;
      alu_valid <= req_valid;
      alu_byte_op <= req_valid ? req_byte : ~alu_byte_op;
      alu_subtract <= req_valid ? req_sub : ~alu_subtract;
      alu_opa <= req_valid ? req_opa : ~alu_opa;
      alu_opb <= req_valid ? req_opb : ~alu_opb;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the CPU status flag bank
`timescale 1ns/10ps
module tb_top;
  logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest, irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, st;
  logic [3:0] avs_byteenable, cpu_priority_level;
  logic [1:0] req_ovf, req_clip, ovf, clip;
  logic req_loop, req_valid, req_byte, req_sub, loop_active, alu_valid, alu_byte_op, alu_subtract;
  logic [15:0] req_opa, req_opb, alu_opa, alu_opb;
  logic [2:0] p;
  integer seed = 32'hc1d4a86e;
  int failures = 0;
  int n_tests = 0;
  csf_status_bank csf_status_bank_inst (.clk_sys(clk_sys), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .acc_alpha_overflow(ovf[1]), .acc_beta_overflow(ovf[0]),
    .acc_alpha_clip_event(clip[1]), .acc_beta_clip_event(clip[0]),
    .loop_active_in(loop_active), .alu_valid(alu_valid), .alu_byte_op(alu_byte_op),
    .alu_subtract(alu_subtract), .alu_opa(alu_opa), .alu_opb(alu_opb),
    .cpu_priority_level(cpu_priority_level), .irq(irq));
  csf_core_model csf_core_model_inst (.clk_sys(clk_sys), .rstn(rstn), .req_ovf(req_ovf),
    .req_clip(req_clip), .req_loop(req_loop), .req_valid(req_valid), .req_byte(req_byte),
    .req_sub(req_sub), .req_opa(req_opa), .req_opb(req_opb), .ovf(ovf), .clip(clip),
    .loop_active(loop_active), .alu_valid(alu_valid), .alu_byte_op(alu_byte_op),
    .alu_subtract(alu_subtract), .alu_opa(alu_opa), .alu_opb(alu_opb));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  always #12.5 clk_sys = ~clk_sys;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  // Avalon cycle: hold until waitrequest is sampled low at a rising edge, take data there
  // No local limit: only the watchdog ends a wait that never completes
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] be);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge clk_sys);
    end
    st = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask
  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  // Core request lasting one cycle, then let it reach the status word
  task automatic pulse_clip(input logic [1:0] c);
    @(posedge clk_sys);
    req_clip <= c;
    @(posedge clk_sys);
    req_clip <= 2'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  // Carry out of the low nibble (byte) or low byte (word)
  function automatic logic hc(input logic [15:0] a, input logic [15:0] b, input logic s,
    input logic y);
    logic [15:0] bb;
    logic [8:0] t;
    bb = s ? ~b : b;
    t = y ? ({5'h00, a[3:0]} + {5'h00, bb[3:0]} + s) : ({1'b0, a[7:0]} + {1'b0, bb[7:0]} + s);
    return y ? t[4] : t[8];
  endfunction
  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial
  begin
    {clk_sys, rstn, avs_read, avs_write, req_loop, req_valid, req_byte, req_sub} = 8'h00;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    {req_ovf, req_clip, req_opa, req_opb} = '0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rd(5'(i * 4)); // Reset values, write-only clear and unmapped read zero
      chk("reset", 32'h0, st);
    end
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      req_ovf <= 2'(i);
      repeat (3) @(posedge clk_sys);
      rd(csf_pkg::OFS_STATUS);
      chk("ovf", {2'(i), 1'b0, 1'b0, |2'(i)}, st[15:11]);
    end
    req_ovf <= 2'h0;
    $display("test overflow done");
    pulse_clip(2'b10);
    rd(csf_pkg::OFS_STATUS);
    chk("clip", 3'b101, {st[13:12], st[10]});
    repeat (20) @(posedge clk_sys);
    rd(csf_pkg::OFS_STATUS);
    chk("sticky", 3'b101, {st[13:12], st[10]});
    wr(csf_pkg::OFS_STATUS, 32'h1400, 4'h2);
    rd(csf_pkg::OFS_STATUS);
    chk("load", 3'b011, {st[13:12], st[10]});
    wr(csf_pkg::OFS_STATUS, 32'h3000, 4'h2);
    rd(csf_pkg::OFS_STATUS);
    chk("clear", 3'b000, {st[13:12], st[10]});
    $display("test sticky done");
    for (int i = 0; i < 2; i++)
    begin
      req_loop <= !i;
      repeat (3) @(posedge clk_sys);
      rd(csf_pkg::OFS_STATUS);
      chk("loop", !i, st[9]);
    end
    $display("test loop done");
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk_sys);
      req_opa <= (i == 0) ? 16'h000f : (i == 1) ? 16'h00ff : 16'($random(seed));
      req_opb <= (i < 2) ? 16'h0001 : 16'($random(seed));
      req_sub <= (i < 2) ? 1'b0 : 1'($random(seed));
      req_byte <= (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($random(seed));
      req_valid <= 1'b1;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rd(csf_pkg::OFS_STATUS);
      chk("half", hc(req_opa, req_opb, req_sub, req_byte), st[8]);
    end
    $display("test half carry done");
    p = 3'($random(seed));
    wr(csf_pkg::OFS_IRQ_CTL, 32'h0, 4'hf);
    wr(csf_pkg::OFS_STATUS, {24'h0, p, 5'h00}, 4'h1);
    wr(csf_pkg::OFS_CORE_CTL, 32'h8, 4'hf);
    rd(csf_pkg::OFS_STATUS);
    chk("prio", p, st[7:5]);
    chk("level", {1'b1, p}, cpu_priority_level);
    wr(csf_pkg::OFS_IRQ_CTL, 32'h8000, 4'hf);
    wr(csf_pkg::OFS_STATUS, {24'h0, ~p, 5'h00}, 4'h1);
    rd(csf_pkg::OFS_STATUS);
    chk("locked", p, st[7:5]);
    $display("test priority done");
    wr(csf_pkg::OFS_EVT_EN, 32'h7, 4'hf);
    wr(csf_pkg::OFS_EVT_CLR, 32'h7, 4'hf);
    @(negedge clk_sys); // Clear lands on the completion edge, look once it has settled
    chk("irq idle", 1'b0, irq);
    pulse_clip(2'b01);
    chk("irq set", 1'b1, irq);
    wr(csf_pkg::OFS_EVT_EN, 32'h0, 4'hf);
    @(negedge clk_sys);
    chk("irq mask", 1'b0, irq);
    wr(csf_pkg::OFS_EVT_STAT, 32'h0, 4'hf);
    rd(csf_pkg::OFS_EVT_STAT);
    chk("evt", 32'h1, st);
    wr(csf_pkg::OFS_EVT_EN, 32'h1, 4'hf);
    @(negedge clk_sys);
    chk("irq unmask", 1'b1, irq);
    wr(csf_pkg::OFS_EVT_CLR, 32'h1, 4'hf);
    rd(csf_pkg::OFS_EVT_STAT);
    chk("evt clr", 32'h0, st);
    chk("irq clr", 1'b0, irq);
    $display("test interrupt done");
    finish_test();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
endmodule
